// [irap_pkg.sv]
// Constants for the I2C register access port
package irap_pkg;
    localparam logic [6:0] IRAP_TARGET_ADDR = 7'h51;
    localparam logic [7:0] IRAP_PTR_MAX = 8'h2F;
    localparam logic [7:0] IRAP_PTR_RST = 8'h00;
    localparam logic [3:0] IRAP_BIT_LAST = 4'h7;
    localparam logic [3:0] IRAP_BIT_ACK = 4'h8;
    localparam int IRAP_PTR_W = 6;
endpackage

// [irap_sync.sv]
// Two-stage synchroniser with edge detection for one pin
`timescale 1ns/1ps
module irap_sync (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic pin_i,
    output logic lvl_o,
    output logic rise_o,
    output logic fall_o
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // Idle bus level is high, so reset to high
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            prev_r <= 1'b1;
        end else begin
            meta_r <= pin_i;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign lvl_o = sync_r;
    assign rise_o = sync_r & ~prev_r;
    assign fall_o = ~sync_r & prev_r;
endmodule

// [irap_target.sv]
// I2C target front-end giving register space access 00h..2Fh
// What this block does
// (R1) First write byte after address is the pointer, valid 00h to 2Fh.
// (R2) Out-of-range pointer discards the transfer but every byte is still acked.
// (R3) Any number of data bytes, zero upward, follow the pointer.
// (R4) Pointer advances after each written byte, 2Fh wraps to 00h.
// (R5) Reads start at the current pointer, no pointer byte in the read.
// (R6) Controller sets the pointer by a write holding only the pointer byte.
// (R7) After read address ack, data is driven at once, MSB first.
// (R8) Pointer advances after each read byte, 2Fh wraps to 00h.
// (R9) Controller acks bytes it wants more of and nacks the last.
// (R10) Only target address 1010 001 answers; bit 0 is direction.
// (R11) Controller sends A2h to write and A3h to read.
// (R12) Each received byte is acknowledged by pulling data low in clock nine.
// (R13) On backup supply the interface is off and ignores the bus.
// (R14) Pointer holds its value between transactions.
// (R15) After a controller nack the data line is released until STOP or START.
`timescale 1ns/1ps
module irap_target
    import irap_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic on_battery_i,
    output logic reg_we_o,
    output logic [5:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i,
    output logic busy_o
);
    // ------------------------------------------------------------
    // Pin conditioning
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_ADDR = 6'b000010,
        ST_PTR  = 6'b000100,
        ST_WR   = 6'b001000,
        ST_RD   = 6'b010000,
        ST_WAIT = 6'b100000
    } irap_state_e;

    logic scl_lvl, scl_rise, scl_fall;
    logic sda_lvl, sda_rise, sda_fall;
    logic batt_meta_r, batt_r;

    irap_sync u_scl (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .pin_i(scl_i),
        .lvl_o(scl_lvl), .rise_o(scl_rise), .fall_o(scl_fall));
    irap_sync u_sda (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .pin_i(sda_i),
        .lvl_o(sda_lvl), .rise_o(sda_rise), .fall_o(sda_fall));

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            batt_meta_r <= 1'b0;
            batt_r <= 1'b0;
        end else begin
            batt_meta_r <= on_battery_i;
            batt_r <= batt_meta_r;
        end
    end

    logic start_det, stop_det;
    assign start_det = scl_lvl & sda_fall;
    assign stop_det = scl_lvl & sda_rise;

    // ------------------------------------------------------------
    // Byte engine
    // ------------------------------------------------------------
    irap_state_e state_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic [5:0] ptr_r;
    logic discard_r;
    logic ack_phase_r;
    logic rd_nack_r;
    // Set while the ninth clock after a read address is ours to acknowledge
    logic addr_ack_r;

    function automatic logic [5:0] ptr_inc(input logic [5:0] p);
        if ({2'b00, p} == IRAP_PTR_MAX) begin
            ptr_inc = IRAP_PTR_RST[5:0];
        end else begin
            ptr_inc = p + 6'h01;
        end
    endfunction

    logic byte_done;
    assign byte_done = scl_fall & (bit_cnt_r == IRAP_BIT_LAST) & ~ack_phase_r;
    logic [7:0] rx_byte;
    assign rx_byte = shift_r;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            shift_r <= 8'h00;
        end else if (scl_rise & ~ack_phase_r) begin
            shift_r <= {shift_r[6:0], sda_lvl};
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_r <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            ack_phase_r <= 1'b0;
            discard_r <= 1'b0;
            rd_nack_r <= 1'b0;
            addr_ack_r <= 1'b0;
            // (R14) reset loads pointer with 00h (wrap also loads 00h), held between transactions
            ptr_r <= IRAP_PTR_RST[5:0];
            tx_r <= 8'h00;
            reg_we_o <= 1'b0;
            reg_wdata_o <= 8'h00;
        end else begin
            reg_we_o <= 1'b0;
            // (R13) battery gate
            if (batt_r) begin
                state_r <= ST_IDLE;
                ack_phase_r <= 1'b0;
                addr_ack_r <= 1'b0;
            end else if (start_det) begin
                state_r <= ST_ADDR;
                // The clock fall that closes START would count a bit, so it lands on zero
                bit_cnt_r <= 4'hF;
                ack_phase_r <= 1'b0;
                addr_ack_r <= 1'b0;
            end else if (stop_det) begin
                state_r <= ST_IDLE;
                ack_phase_r <= 1'b0;
                addr_ack_r <= 1'b0;
            end else if (state_r != ST_IDLE && state_r != ST_WAIT && scl_fall) begin
                if (ack_phase_r) begin
                    // End of ninth clock
                    ack_phase_r <= 1'b0;
                    addr_ack_r <= 1'b0;
                    bit_cnt_r <= 4'h0;
                    if (state_r == ST_RD) begin
                        // (R15) nack ends reading
                        if (rd_nack_r) begin
                            state_r <= ST_WAIT;
                        end else begin
                            // (R7) next byte MSB first
                            tx_r <= reg_rdata_i;
                        end
                    end
                end else if (byte_done) begin
                    ack_phase_r <= 1'b1;
                    case (state_r)
                        ST_ADDR: begin
                            // (R10) address match
                            if (rx_byte[7:1] != IRAP_TARGET_ADDR) begin
                                state_r <= ST_WAIT;
                                ack_phase_r <= 1'b0;
                            end else if (rx_byte[0]) begin
                                // (R5) read from pointer
                                state_r <= ST_RD;
                                addr_ack_r <= 1'b1;
                                tx_r <= reg_rdata_i;
                            end else begin
                                state_r <= ST_PTR;
                            end
                        end
                        ST_PTR: begin
                            // (R1) pointer range
                            // (R2) discard but ack
                            discard_r <= rx_byte > IRAP_PTR_MAX;
                            if (rx_byte <= IRAP_PTR_MAX) begin
                                ptr_r <= rx_byte[5:0];
                            end
                            state_r <= ST_WR;
                        end
                        ST_WR: begin
                            // (R3) unbounded data bytes
                            // (R4) write advance
                            if (!discard_r) begin
                                reg_we_o <= 1'b1;
                                reg_wdata_o <= rx_byte;
                                ptr_r <= ptr_inc(ptr_r);
                            end
                        end
                        ST_RD: begin
                            // (R8) read advance
                            ptr_r <= ptr_inc(ptr_r);
                        end
                        default: state_r <= ST_IDLE;
                    endcase
                end else begin
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                    if (state_r == ST_RD) begin
                        tx_r <= {tx_r[6:0], 1'b0};
                    end
                end
            end else if (state_r == ST_RD && ack_phase_r && scl_rise) begin
                rd_nack_r <= sda_lvl;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    logic drive_low;
    always_comb begin
        drive_low = 1'b0;
        if (ack_phase_r && (state_r != ST_RD || addr_ack_r)) begin
            // (R12) ack in ninth clock
            drive_low = 1'b1;
        end else if (state_r == ST_RD && !ack_phase_r) begin
            drive_low = ~tx_r[7];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            reg_addr_o <= 6'h00;
            busy_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
            sda_oe_o <= drive_low & ~batt_r;
            reg_addr_o <= ptr_r;
            busy_o <= (state_r != ST_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence rd_ack_s;
        state_r == ST_RD && ack_phase_r && scl_fall && !rd_nack_r && !start_det && !stop_det
            && !batt_r;
    endsequence

    ptr_wrap_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // (R4)
        (reg_we_o && $past(ptr_r) == 6'h2F) |-> ptr_r == 6'h00)
        else $error("pointer did not wrap");
    discard_we_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // (R2)
        reg_we_o |-> !discard_r)
        else $error("write during discarded transfer");
    batt_quiet_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // (R13)
        batt_r |=> !sda_oe_o)
        else $error("drive while on battery");
    ptr_range_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // (R1)
        ptr_r <= 6'h2F)
        else $error("pointer out of range");
    nack_release_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // (R15)
        state_r == ST_WAIT |=> !sda_oe_o)
        else $error("drive after nack");
    ptr_hold_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // (R14)
        (state_r == ST_IDLE && $past(state_r) == ST_IDLE) |-> $stable(ptr_r))
        else $error("pointer moved while idle");
    rd_next_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // (R7)
        rd_ack_s |=> state_r == ST_RD && bit_cnt_r == 4'h0)
        else $error("read did not continue");
    ack_drive_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // (R12)
        (ack_phase_r && state_r == ST_WR && !batt_r) |=> sda_oe_o)
        else $error("missing ack");
    rd_addr_ack_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // (R10)
        (ack_phase_r && state_r == ST_RD && addr_ack_r && !batt_r) |=> sda_oe_o)
        else $error("read address not acknowledged");
endmodule

// [irap_i2c_ctrl.sv]
// Behavioural I2C bus controller that stands on the far side of the port
`timescale 1ns/1ps
module irap_i2c_ctrl (
    input wire logic ref_clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // Eight cycles each phase leaves room for the port's sync latency
    localparam int HALF = 8;
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic start_c();
        sda_low_o = 1'b0;
        hold(HALF);
        scl_o = 1'b1;
        hold(HALF);
        sda_low_o = 1'b1;
        hold(HALF);
        scl_o = 1'b0;
        hold(2);
    endtask
    task automatic stop_c();
        sda_low_o = 1'b1;
        hold(HALF);
        scl_o = 1'b1;
        hold(HALF);
        sda_low_o = 1'b0;
        hold(HALF);
    endtask
    // Data only moves while the clock is low, so no false start or stop
    task automatic bit_c(input logic b, output logic r);
        sda_low_o = !b;
        hold(HALF);
        scl_o = 1'b1;
        hold(HALF / 2);
        r = sda_i;
        hold(HALF / 2);
        scl_o = 1'b0;
        hold(2);
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_c(d[i], r);
        bit_c(1'b1, r);
        ack = !r;
    endtask
    task automatic rd_byte(input logic last, output logic [7:0] d, output logic r);
        for (int i = 7; i >= 0; i--) bit_c(1'b1, d[i]);
        bit_c(last, r);
    endtask
endmodule

// [irap_target_tb_top.sv]
// Self-checking bench for the I2C register access port
`timescale 1ns/1ps
module irap_target_tb_top import irap_pkg::*; ();
    logic ref_clk_i, srst_i, scl, sda_low, sda_w, on_battery;
    logic sda_o, sda_oe_o, reg_we_o, busy_o, a;
    logic [5:0] reg_addr_o;
    logic [7:0] reg_wdata_o, reg_rdata_i;
    logic [7:0] regs [48];
    int exp_mem [48];
    int ptr, n_errors, checks;
    logic [7:0] bad_addr [4] = '{8'hA0, 8'hA4, 8'h22, 8'hE3};
    assign sda_w = (sda_low || (sda_oe_o && sda_o === 1'b0)) ? 1'b0 : 1'b1;
    assign reg_rdata_i = (reg_addr_o < 6'h30) ? regs[reg_addr_o] : 8'hA5;
    irap_target u_irap_target (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .scl_i(scl),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .on_battery_i(on_battery),
        .reg_we_o(reg_we_o), .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o),
        .reg_rdata_i(reg_rdata_i), .busy_o(busy_o));
    irap_i2c_ctrl u_irap_i2c_ctrl (.ref_clk_i(ref_clk_i), .sda_i(sda_w), .scl_o(scl),
        .sda_low_o(sda_low));
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        if (reg_we_o === 1'b1 && reg_addr_o < 6'h30) regs[reg_addr_o] <= reg_wdata_o;
        else if (reg_we_o === 1'b1) fail("write outside map");
    end
    // ----------------------------------------
    // Checking and transfer tasks
    // ----------------------------------------
    task automatic fail(input string msg);
        n_errors++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) fail("bus bit");
    endtask
    task automatic chk_byte(input logic [7:0] got, input int exp);
        checks++;
        if (got !== exp[7:0]) fail($sformatf("byte %h expected %h", got, exp[7:0]));
    endtask
    task automatic chk_mem();
        for (int i = 0; i < 48; i++) chk_byte(regs[i], exp_mem[i]);
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic do_write(input int p, input int n, input logic stop);
        logic [7:0] d;
        u_irap_i2c_ctrl.start_c();
        chk_bit(busy_o, 1'b1);
        u_irap_i2c_ctrl.wr_byte(8'hA2, a);
        chk_bit(a, 1'b1);
        u_irap_i2c_ctrl.wr_byte(p[7:0], a);
        chk_bit(a, 1'b1);
        if (p < 48) ptr = p;
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            u_irap_i2c_ctrl.wr_byte(d, a);
            chk_bit(a, 1'b1);
            if (p < 48) exp_mem[ptr] = d;
            if (p < 48) ptr = (ptr + 1) % 48;
        end
        if (stop) begin
            u_irap_i2c_ctrl.stop_c();
            chk_bit(busy_o, 1'b0);
        end
    endtask
    task automatic do_read(input int n);
        logic r;
        logic [7:0] d;
        u_irap_i2c_ctrl.start_c();
        u_irap_i2c_ctrl.wr_byte(8'hA3, a);
        chk_bit(a, 1'b1);
        for (int i = 0; i < n; i++) begin
            u_irap_i2c_ctrl.rd_byte(i == n - 1, d, r);
            chk_byte(d, exp_mem[ptr]);
            ptr = (ptr + 1) % 48;
        end
        chk_bit(r, 1'b1);
        u_irap_i2c_ctrl.stop_c();
        chk_bit(busy_o, 1'b0);
    endtask
    initial begin
        repeat (60000) @(posedge ref_clk_i);
        fail("watchdog expired");
        end_sim();
    end
    initial begin
        srst_i = 1'b1;
        on_battery = 1'b0;
        n_errors = 0;
        checks = 0;
        ptr = 0;
        void'($urandom(27851));
        for (int i = 0; i < 48; i++) regs[i] = 8'($urandom);
        for (int i = 0; i < 48; i++) exp_mem[i] = regs[i];
        repeat (6) @(posedge ref_clk_i);
        #1;
        srst_i = 1'b0;
        u_irap_i2c_ctrl.hold(4);
        do_write(46, 4, 1'b1);
        for (int i = 0; i < 3; i++) do_write($urandom % 48, $urandom % 5, 1'b1);
        chk_mem();
        $display("test write done");
        do_write(47, 0, 1'b0);
        do_read(3);
        do_read(2);
        $display("test read done");
        do_write(48, 2, 1'b1);
        do_write(255, 2, 1'b1);
        do_write(48 + $urandom % 208, 1, 1'b1);
        chk_mem();
        $display("test bad pointer done");
        foreach (bad_addr[i]) begin
            u_irap_i2c_ctrl.start_c();
            u_irap_i2c_ctrl.wr_byte(bad_addr[i], a);
            chk_bit(a, 1'b0);
            u_irap_i2c_ctrl.stop_c();
        end
        $display("test foreign address done");
        on_battery = 1'b1;
        u_irap_i2c_ctrl.hold(8);
        u_irap_i2c_ctrl.start_c();
        chk_bit(busy_o, 1'b0);
        u_irap_i2c_ctrl.wr_byte(8'hA2, a);
        chk_bit(a, 1'b0);
        u_irap_i2c_ctrl.stop_c();
        on_battery = 1'b0;
        u_irap_i2c_ctrl.hold(8);
        do_write(5, 1, 1'b1);
        chk_mem();
        $display("test battery done");
        end_sim();
    end
endmodule
